// ---- core/fsbu_consts.vh ----
`ifndef FSBU_CONSTS_VH
`define FSBU_CONSTS_VH
`define FSBU_CMD_ERASE_BLK   8'h09
`define FSBU_CMD_ERASE_SEC   8'h0a
`define FSBU_CMD_UNSECURE    8'h0b
`define FSBU_CMD_VERIFY_KEY  8'h0c
`define FSBU_CMD_USER_MARGIN 8'h0d
`define FSBU_CMD_FIELD_MARGIN 8'h0e
`define FSBU_CMD_ERASE_ALL   8'h08
`define FSBU_SEC_UNSECURE    2'h2
`define FSBU_BACKDOOR_KEY_ENABLE_ENABLED   2'h2
`define FSBU_KEY_ZERO        16'h0000
`define FSBU_KEY_ONES        16'hffff
`define FSBU_BAD_DATA        16'hffff
`define FSBU_VERIFY_CYC      20'h0018e
`define FSBU_USER_MARGIN_CYC 20'h0015c
`define FSBU_FIELD_MARGIN_CYC 20'h0015d
`define FSBU_SEC_BUS_CYC     20'h0044b
`define FSBU_BLK_BUS_CYC_256 20'h1116f
`define FSBU_BLK_BUS_CYC_128 20'h088b7
`define FSBU_OP_CYC          20'h18703
`define FSBU_SEC_OP_CYC      20'h04e33
`endif

// ---- core/fsbu_top.v ----
`timescale 1ns/100ps
`include "fsbu_consts.vh"
module fsbu_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        nvm_op_en,
  input  wire        cmd_launch,
  input  wire [7:0]  flash_command_code,
  input  wire [63:0] cmd_keys,
  input  wire        blk_is_128k,
  input  wire [63:0] stored_keys,
  input  wire [1:0]  stored_security_byte,
  input  wire [1:0]  backdoor_key_enable,
  input  wire [7:0]  protection_in,
  input  wire        blk0_rd_req,
  input  wire [15:0] blk0_rd_raw,
  output reg  [1:0]  security_state_field,
  output reg  [7:0]  protection_register,
  output reg         command_complete_flag,
  output reg         verify_blocked_ff,
  output reg         verify_busy_ff,
  output reg         cmd_error_ff,
  output reg         sec_sector_write_ok_ff,
  output reg  [15:0] blk0_rd_data_ff
);
  localparam ST_IDLE = 2'h0;
  localparam ST_BUS  = 2'h1;
  localparam ST_OP   = 2'h2;

  reg  [1:0]  state_ff;
  reg  [19:0] bus_cnt_ff;
  reg  [19:0] op_cnt_ff;
  reg  [7:0]  cmd_ff;
  reg         loaded_ff;
  reg  [1:0]  op_en_sync_ff;
  reg  [19:0] nxt_bus_cnt;
  reg  [19:0] nxt_op_cnt;
  reg         nxt_launch_err;
  reg         nxt_launch_verify;
  wire        op_tick;
  wire [3:0]  word_ok;
  wire        keys_ok;
  wire        key_accept;
  wire        launch_ok;
  wire        bus_done;
  wire        op_done;
  wire        verify_end;

  genvar      w;

  // The operating tick comes from another domain, so only the second flop is read.
  assign op_tick = op_en_sync_ff[1];

  generate
    for (w = 0; w < 4; w = w + 1) begin : g_key_word
      // A forbidden stored key word keeps the door shut even on a match.
      assign word_ok[w] = (stored_keys[w*16 +: 16] != `FSBU_KEY_ZERO) &&
                          (stored_keys[w*16 +: 16] != `FSBU_KEY_ONES) &&
                          (stored_keys[w*16 +: 16] == cmd_keys[w*16 +: 16]);
    end
  endgenerate

  assign keys_ok    = &word_ok;
  assign key_accept = keys_ok && (backdoor_key_enable == `FSBU_BACKDOOR_KEY_ENABLE_ENABLED);
  assign launch_ok  = (state_ff == ST_IDLE) && cmd_launch &&
                      command_complete_flag && loaded_ff;
  assign bus_done   = (state_ff == ST_BUS) && (bus_cnt_ff == 20'h0);
  assign op_done    = (state_ff == ST_OP) && (op_cnt_ff == 20'h0);
  assign verify_end = bus_done && (cmd_ff == `FSBU_CMD_VERIFY_KEY) && verify_busy_ff;

  // The verify and user margin bus budgets are two short of their limits, to cover the entry and exit cycles; the others are one short.
  always @* begin
    nxt_bus_cnt       = 20'h0;
    nxt_op_cnt        = 20'h0;
    nxt_launch_err    = 1'b0;
    nxt_launch_verify = 1'b0;
    case (flash_command_code)
      `FSBU_CMD_VERIFY_KEY: begin
        if (verify_blocked_ff) begin
          nxt_launch_err = 1'b1;
        end else begin
          nxt_launch_verify = 1'b1;
          nxt_bus_cnt       = `FSBU_VERIFY_CYC;
        end
      end
      `FSBU_CMD_ERASE_BLK: begin
        nxt_op_cnt  = `FSBU_OP_CYC;
        nxt_bus_cnt = blk_is_128k ? `FSBU_BLK_BUS_CYC_128 : `FSBU_BLK_BUS_CYC_256;
      end
      `FSBU_CMD_ERASE_SEC: begin
        nxt_op_cnt  = `FSBU_SEC_OP_CYC;
        nxt_bus_cnt = `FSBU_SEC_BUS_CYC;
      end
      `FSBU_CMD_UNSECURE, `FSBU_CMD_ERASE_ALL: begin
        nxt_op_cnt  = `FSBU_OP_CYC;
        nxt_bus_cnt = `FSBU_BLK_BUS_CYC_256;
      end
      `FSBU_CMD_USER_MARGIN: begin
        nxt_bus_cnt = `FSBU_USER_MARGIN_CYC;
      end
      `FSBU_CMD_FIELD_MARGIN: begin
        nxt_bus_cnt = `FSBU_FIELD_MARGIN_CYC;
      end
      default: begin
        nxt_launch_err = 1'b1;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      op_en_sync_ff <= 2'h0;
    end else begin
      op_en_sync_ff <= {op_en_sync_ff[0], nvm_op_en};
    end
  end

  // Security is reloaded from the stored byte after every reset, so an unlock is temporary.
  always @(posedge ref_clk) begin
    if (rst) begin
      loaded_ff           <= 1'b0;
      protection_register <= 8'h0;
    end else if (!loaded_ff) begin
      loaded_ff           <= 1'b1;
      protection_register <= protection_in;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      security_state_field <= 2'h0;
    end else if (!loaded_ff) begin
      security_state_field <= stored_security_byte;
    end else if (verify_end && key_accept) begin
      security_state_field <= `FSBU_SEC_UNSECURE;
    end
  end

  // Keys and protection are only read by the verify, never written.
  always @(posedge ref_clk) begin
    if (rst) begin
      verify_blocked_ff <= 1'b0;
    end else if (verify_end && !key_accept) begin
      verify_blocked_ff <= 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      verify_busy_ff <= 1'b0;
    end else if (launch_ok) begin
      verify_busy_ff <= nxt_launch_verify;
    end else if (verify_end) begin
      verify_busy_ff <= 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      cmd_error_ff <= 1'b0;
    end else if (launch_ok) begin
      cmd_error_ff <= nxt_launch_err;
    end else if (verify_end && !key_accept) begin
      cmd_error_ff <= 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      command_complete_flag <= 1'b1;
    end else if (launch_ok) begin
      command_complete_flag <= 1'b0;
    end else if (op_done) begin
      command_complete_flag <= 1'b1;
    end
  end

  // Only an unsecured part may touch the sector that holds the security byte.
  always @(posedge ref_clk) begin
    if (rst) begin
      sec_sector_write_ok_ff <= 1'b0;
    end else begin
      sec_sector_write_ok_ff <= (security_state_field == `FSBU_SEC_UNSECURE);
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      blk0_rd_data_ff <= 16'h0;
    end else if (blk0_rd_req) begin
      blk0_rd_data_ff <= verify_busy_ff ? `FSBU_BAD_DATA : blk0_rd_raw;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      bus_cnt_ff <= 20'h0;
      op_cnt_ff  <= 20'h0;
      cmd_ff     <= 8'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (launch_ok) begin
            cmd_ff     <= flash_command_code;
            bus_cnt_ff <= nxt_bus_cnt;
            op_cnt_ff  <= nxt_op_cnt;
            state_ff   <= ST_BUS;
          end
        end
        ST_BUS: begin
          if (bus_done) begin
            state_ff <= ST_OP;
          end else begin
            bus_cnt_ff <= bus_cnt_ff - 20'h1;
          end
        end
        ST_OP: begin
          if (op_done) begin
            state_ff <= ST_IDLE;
          end else if (op_tick) begin
            op_cnt_ff <= op_cnt_ff - 20'h1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- tb/fsbu_monitor.sv ----
`timescale 1ns/100ps
module fsbu_monitor (
  input wire        ref_clk,
  input wire        rst,
  input wire        cmd_launch,
  input wire [1:0]  backdoor_key_enable,
  input wire [1:0]  security_state_field,
  input wire [7:0]  protection_register,
  input wire        command_complete_flag,
  input wire        verify_blocked_ff,
  input wire        verify_busy_ff,
  input wire [15:0] blk0_rd_data_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  unlock_rule_a: assert property (!$past(rst, 2) && $changed(security_state_field) |->
    security_state_field == 2'h2 && backdoor_key_enable == 2'h2) else $error("bad unlock");
  prot_hold_a: assert property (!$past(rst, 2) |-> $stable(protection_register))
    else $error("protection moved");
  blk0_guard_a: assert property (verify_busy_ff && $past(verify_busy_ff) |->
    blk0_rd_data_ff == 16'hffff) else $error("block 0 read served");
  verify_time_a: assert property ($fell(command_complete_flag) && verify_busy_ff |->
    ##[1:399] command_complete_flag) else $error("verify too slow");
  launch_clear_a: assert property (!$past(rst) && cmd_launch && command_complete_flag |=>
    !command_complete_flag) else $error("flag kept on launch");
  block_sticky_a: assert property (verify_blocked_ff |=> verify_blocked_ff)
    else $error("block lifted");
  unlock_sticky_a: assert property (security_state_field == 2'h2 |=>
    security_state_field == 2'h2) else $error("unlock lost");
  blocked_hold_a: assert property (verify_blocked_ff |-> $stable(security_state_field))
    else $error("unlock while blocked");
endmodule
bind fsbu_top fsbu_monitor u_mon (.ref_clk, .rst, .cmd_launch, .backdoor_key_enable,
  .security_state_field, .protection_register, .command_complete_flag,
  .verify_blocked_ff, .verify_busy_ff, .blk0_rd_data_ff);

// ---- tb/fsbu_host.sv ----
`timescale 1ns/100ps
module fsbu_host (
  input  wire        ref_clk,
  input  wire        go,
  input  wire [7:0]  code,
  input  wire [63:0] keys,
  input  wire        complete_in,
  output reg         cmd_launch = 1'b0,
  output reg  [7:0]  code_out = 8'h00,
  output reg  [63:0] keys_out = 64'h0
);
  // Keys are held after launch because the block compares them only at the end.
  always @(posedge ref_clk) begin
    if (go && complete_in && !cmd_launch) begin
      cmd_launch <= 1'b1;
      code_out   <= code;
      keys_out   <= keys;
    end else if (!complete_in) begin
      cmd_launch <= 1'b0;
    end
  end
endmodule

// ---- tb/fsbu_top_bench.sv ----
`timescale 1ns/100ps
module fsbu_top_bench;
  reg         ref_clk = 0, rst = 1, go = 0;
  reg  [1:0]  ken = 2'h2, es = 2'h0;
  reg  [15:0] skl = 16'h0, pkl = 16'h0;
  reg  [7:0]  code = 8'h00;
  wire        la, done, blk, busy, err, wok;
  wire [7:0]  fc, prot;
  wire [63:0] ck;
  wire [1:0]  sec;
  wire [15:0] rd;
  integer     errors = 0, samples_checked = 0, i, n;
  reg  [35:0] rows [0:4];
  always #5 ref_clk = ~ref_clk;
  fsbu_host host (.ref_clk(ref_clk), .go(go), .code(code), .keys({48'h1111_2222_3333, pkl}),
    .complete_in(done), .cmd_launch(la), .code_out(fc), .keys_out(ck));
  fsbu_top dut (.ref_clk(ref_clk), .rst(rst), .nvm_op_en(1'b1), .cmd_launch(la),
    .flash_command_code(fc), .cmd_keys(ck), .blk_is_128k(1'b0), .blk0_rd_req(~rst),
    .stored_keys({48'h1111_2222_3333, skl}), .stored_security_byte(2'h3),
    .backdoor_key_enable(ken), .protection_in(8'h5a), .blk0_rd_raw(16'h1234),
    .security_state_field(sec), .protection_register(prot), .command_complete_flag(done),
    .verify_blocked_ff(blk), .verify_busy_ff(busy), .cmd_error_ff(err),
    .sec_sector_write_ok_ff(wok), .blk0_rd_data_ff(rd));
  task check(input [63:0] seen, input [63:0] exp, input [95:0] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED %0s exp %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task run(input [7:0] c);
    begin
      code <= c;
      go <= 1'b1;
      for (n = 0; done && n < 20; n = n + 1) @(posedge ref_clk);
      go <= 1'b0;
      for (n = 0; !done && n < 999; n = n + 1) @(posedge ref_clk);
    end
  endtask
  task reset;
    begin
      rst <= 1'b1;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    end_sim;
  end
  initial begin
    rows[0] = {2'h1, 32'h4444_4444, 2'h3};
    rows[1] = {2'h2, 32'h0000_0000, 2'h3};
    rows[2] = {2'h2, 32'hffff_ffff, 2'h3};
    rows[3] = {2'h2, 32'h4444_4445, 2'h3};
    rows[4] = {2'h2, 32'h4444_4444, 2'h2};
    for (i = 0; i < 5; i = i + 1) begin
      {ken, skl, pkl, es} <= rows[i];
      reset;
      run(8'h0c);
      check(n <= 400, 1'b1, "verify time");
      check(sec, es, "security");
      check(err, es != 2'h2, "verify error");
      check(busy, 1'b0, "verify busy");
      check(rd, 16'h1234, "block 0 read");
      check(prot, 8'h5a, "protection");
    end
    check(wok, 1'b1, "sector ok");
    reset;
    check(sec, 2'h3, "reload");
    pkl <= 16'h4445;
    run(8'h0c);
    pkl <= 16'h4444;
    run(8'h0c);
    check({blk, err, sec}, 4'hf, "blocked");
    reset;
    check(blk, 1'b0, "unblocked");
    run(8'h0d);
    check(n <= 350, 1'b1, "margin time");
    run(8'h0e);
    check(err, 1'b0, "field margin");
    end_sim;
  end
endmodule
